// ---- quadrature_pulse_counter.sv ----
// Purpose: quadrature decoder with per-direction totals and scan pulse accumulators
// Assumes: encoder phases and pulse inputs are asynchronous pins
// Notes: outputs all come from flip-flops; snapshot appears one cycle after scanStart
//        an edge on the scanStart cycle opens the new interval, never the old one
//        resolution changes only while clearCounts is high
//        encoder phases must dwell one cycle or a step may be lost
//
// Summary of operation
// RULE1 - count up A leads, down B leads
// RULE2 - report clockwise A leads, counterclockwise otherwise
// RULE3 - keep separate unsigned per-direction totals
// RULE4 - single: A rise up, A fall down
// RULE5 - double: both A edges change count
// RULE6 - quadruple: every edge of both phases
// RULE7 - dedicated 32-bit accumulator per pulse input
// RULE8 - scan start samples then clears atomically
// RULE9 - host keeps scans short enough, wrap allowed
// RULE10 - accumulator resolves one single count
// RULE11 - two flip-flop sync before any decoding
// RULE12 - two-bit resolution, applied on clear only
module quadrature_pulse_counter
    import quad_counter_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // encoder pins
    input wire logic phaseA,
    input wire logic phaseB,
    // pulse pins
    input wire logic [NUM_PULSE-1:0] pulseIn,
    // control
    input wire logic [1:0] resolutionSel,
    input wire logic clearCounts,
    input wire logic scanStart,
    // results
    output quad_result_t quadResult,
    output logic [NUM_PULSE*CNT_W-1:0] pulseSnapshot,
    output logic snapshotValid
);

    // -------------------------------------------------------------
    // synchronisers
    // -------------------------------------------------------------
    logic [NUM_PULSE+1:0] syncFirst_reg;
    logic [NUM_PULSE+1:0] syncSecond_reg;
    logic [NUM_PULSE+1:0] syncLast_reg;

    // first stage is read only by the second stage; a pin change reaches
    // the counters on the third edge, so pulses under one cycle may be missed
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            syncFirst_reg <= '0;
            syncSecond_reg <= '0;
            syncLast_reg <= '0;
        end else begin
            syncFirst_reg <= {pulseIn, phaseB, phaseA}; // [RULE11]
            syncSecond_reg <= syncFirst_reg; // [RULE11]
            syncLast_reg <= syncSecond_reg;
        end
    end

    // settled phases and their values one cycle earlier
    logic aNow, bNow, aOld, bOld;
    assign aNow = syncSecond_reg[0];
    assign bNow = syncSecond_reg[1];
    assign aOld = syncLast_reg[0];
    assign bOld = syncLast_reg[1];

    // -------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------

    // phases unequal after an A edge means A moved first
    function automatic logic phases_differ(input logic a, input logic b);
        return a ^ b;
    endfunction

    // one count up; wraps at the top, which the host must avoid
    function automatic logic [CNT_W-1:0] count_up(input logic [CNT_W-1:0] value);
        return value + 32'h00000001;
    endfunction

    // one count down for the signed position
    function automatic logic [CNT_W-1:0] count_down(input logic [CNT_W-1:0] value);
        return value - 32'h00000001;
    endfunction

    // code 3 has no mode of its own and falls back to single
    function automatic logic [1:0] legal_res(input logic [1:0] sel);
        return (sel == 2'h3) ? RES_SINGLE : sel;
    endfunction

    // -------------------------------------------------------------
    // quadrature decode
    // -------------------------------------------------------------
    logic [1:0] activeRes_reg;

    // resolution latched only on clear so counts never mix scales;
    // a setting moved between clears is ignored until the next one
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            activeRes_reg <= RES_RESET;
        end else if (clearCounts) begin
            activeRes_reg <= legal_res(resolutionSel); // [RULE12]
        end
    end

    logic aRise, aFall, aEdge, bEdge, phasesApart;
    logic stepUp, stepDown;

    // direction from which phase changed relative to the other:
    // a-edge with a!=b after means A leads; b-edge with a==b after means A leads
    always_comb begin
        aRise = aNow & ~aOld;
        aFall = ~aNow & aOld;
        aEdge = aRise | aFall;
        bEdge = bNow ^ bOld;
        phasesApart = phases_differ(aNow, bNow);
        stepUp = 1'b0;
        stepDown = 1'b0;
        unique case (activeRes_reg)
            RES_DOUBLE: begin
                // edges of B never move the count here
                stepUp = aEdge & ~bEdge & phasesApart; // [RULE5]
                stepDown = aEdge & ~bEdge & ~phasesApart; // [RULE5]
            end
            RES_QUAD: begin
                // both phases at once is an illegal jump and is dropped
                stepUp = (aEdge ^ bEdge) & ((aEdge & phasesApart) |
                         (bEdge & ~phasesApart)); // [RULE6]
                stepDown = (aEdge ^ bEdge) & ((aEdge & ~phasesApart) |
                           (bEdge & phasesApart)); // [RULE6]
            end
            default: begin
                stepUp = aRise & ~bEdge & ~bNow; // [RULE4]
                stepDown = aFall & ~bEdge & ~bNow; // [RULE4]
            end
        endcase
    end

    // -------------------------------------------------------------
    // position, totals and direction
    // -------------------------------------------------------------
    logic [CNT_W-1:0] position_reg;
    logic [CNT_W-1:0] forwardTotal_reg;
    logic [CNT_W-1:0] reverseTotal_reg;
    logic clockwise_reg;

    // signed position; a clear beats a step in the same cycle
    always_ff @(posedge clock) begin
        if (!reset_n || clearCounts) begin
            position_reg <= CNT_RESET;
        end else if (stepUp) begin
            position_reg <= count_up(position_reg); // [RULE1]
        end else if (stepDown) begin
            position_reg <= count_down(position_reg); // [RULE1]
        end
    end

    // per-direction totals only grow, so shaft jitter shows in both
    always_ff @(posedge clock) begin
        if (!reset_n || clearCounts) begin
            forwardTotal_reg <= CNT_RESET;
            reverseTotal_reg <= CNT_RESET;
        end else if (stepUp) begin
            forwardTotal_reg <= count_up(forwardTotal_reg); // [RULE3]
        end else if (stepDown) begin
            reverseTotal_reg <= count_up(reverseTotal_reg); // [RULE3]
        end
    end

    // net direction follows the last counted step
    always_ff @(posedge clock) begin
        if (!reset_n || clearCounts) begin
            clockwise_reg <= DIR_RESET;
        end else if (stepUp) begin
            clockwise_reg <= 1'b1; // [RULE2]
        end else if (stepDown) begin
            clockwise_reg <= 1'b0; // [RULE2]
        end
    end

    // the port is a plain repack of flops with no logic in between
    assign quadResult = {position_reg, forwardTotal_reg, reverseTotal_reg, clockwise_reg};

    // -------------------------------------------------------------
    // pulse accumulators
    // -------------------------------------------------------------
    logic [CNT_W-1:0] pulseAcc_reg [NUM_PULSE];
    logic [NUM_PULSE-1:0] pulseRise;

    // only rising edges count; falls are ignored
    assign pulseRise = syncSecond_reg[NUM_PULSE+1:2] & ~syncLast_reg[NUM_PULSE+1:2];

    // on scan start the edge of that cycle seeds the new interval, so none is lost;
    // overflow wraps silently, the host must keep scans short
    always_ff @(posedge clock) begin
        for (int i = 0; i < NUM_PULSE; i++) begin
            if (!reset_n) begin
                pulseAcc_reg[i] <= CNT_RESET;
            end else if (scanStart) begin
                pulseAcc_reg[i] <= {31'h00000000, pulseRise[i]}; // [RULE8]
            end else if (pulseRise[i]) begin
                pulseAcc_reg[i] <= count_up(pulseAcc_reg[i]); // [RULE7] [RULE10] [RULE9]
            end
        end
    end

    // snapshot taken in the same cycle as the clear;
    // it holds until the next scan so a slow reader still sees it
    always_ff @(posedge clock) begin
        if (!reset_n) begin
            pulseSnapshot <= '0;
            snapshotValid <= 1'b0;
        end else begin
            snapshotValid <= scanStart;
            if (scanStart) begin
                for (int i = 0; i < NUM_PULSE; i++) begin
                    pulseSnapshot[i*CNT_W +: CNT_W] <= pulseAcc_reg[i]; // [RULE8]
                end
            end
        end
    end

endmodule

// ---- quad_counter_pkg.sv ----
// Purpose: shared constants and types for the quadrature and pulse counter
// Assumes: single 125 MHz clock, synchronous active-low reset
// Notes: no software registers; all control is by ports
package quad_counter_pkg;

    localparam int unsigned NUM_PULSE = 2;
    localparam int unsigned CNT_W = 32;
    localparam int unsigned SYNC_STAGES = 2;

    // counting resolution settings
    localparam logic [1:0] RES_SINGLE = 2'h0;
    localparam logic [1:0] RES_DOUBLE = 2'h1;
    localparam logic [1:0] RES_QUAD = 2'h2;

    localparam logic [CNT_W-1:0] CNT_RESET = 32'h00000000;
    localparam logic [1:0] RES_RESET = 2'h0;
    localparam logic DIR_RESET = 1'h1;

    // quadrature results carried together
    typedef struct packed {
        logic [CNT_W-1:0] position;
        logic [CNT_W-1:0] forwardTotal;
        logic [CNT_W-1:0] reverseTotal;
        logic clockwise;
    } quad_result_t;

endpackage

// ---- quad_counter_properties.sv ----
// Purpose: port checks for the counter
// Assumes: one clock, sync reset
// Notes: bound to every counter instance
module quad_counter_properties
    import quad_counter_pkg::*;
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic phaseA,
    input wire logic phaseB,
    input wire logic clearCounts,
    input wire logic scanStart,
    input wire quad_result_t quadResult,
    input wire logic [NUM_PULSE*CNT_W-1:0] pulseSnapshot,
    input wire logic snapshotValid
);
    timeunit 1ns / 1ps;
    // last edge saw neither reset nor clear
    logic calm_reg;
    wire [31:0] p = quadResult.position;
    wire [31:0] f = quadResult.forwardTotal;
    wire [31:0] r = quadResult.reverseTotal;
    wire cw = quadResult.clockwise;
    always_ff @(posedge clock) calm_reg <= reset_n && !clearCounts;
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    a_snap_follows: assert property (scanStart |=> snapshotValid) else $error("no snap");
    a_snap_cause: assert property (snapshotValid |-> $past(scanStart))
        else $error("stray snap");
    a_snap_holds: assert property (!scanStart |=> $stable(pulseSnapshot))
        else $error("snap moved");
    a_clear_zero: assert property (clearCounts |=> p == '0 && f == '0 && r == '0 && cw)
        else $error("clear failed");
    a_up_step: assert property (calm_reg && f != $past(f) |-> p == $past(p) + 1'h1 && cw)
        else $error("bad up step");
    a_down_step: assert property (calm_reg && r != $past(r) |-> p == $past(p) - 1'h1 && !cw)
        else $error("bad down step");
    a_totals_unit: assert property (calm_reg |-> f - $past(f) <= 1'h1 && r - $past(r) <= 1'h1)
        else $error("total jumped");
    a_idle_still: assert property (($stable(phaseA) && $stable(phaseB)) [*5]
        ##0 calm_reg |-> $stable(p)) else $error("count while idle");
endmodule
bind quadrature_pulse_counter quad_counter_properties u_quad_counter_properties (
    .clock(clock),
    .reset_n(reset_n),
    .phaseA(phaseA),
    .phaseB(phaseB),
    .clearCounts(clearCounts),
    .scanStart(scanStart),
    .quadResult(quadResult),
    .pulseSnapshot(pulseSnapshot),
    .snapshotValid(snapshotValid)
);

// ---- encoder_model.sv ----
// Purpose: shaft encoder with two quadrature phases
// Assumes: stepped on the rising clock edge
// Notes: gray steps only, so both phases never move at once
module encoder_model (
    input wire logic clock,
    output logic phaseA,
    output logic phaseB
);
    timeunit 1ns / 1ps;
    logic [1:0] ph = 2'h0;
    // forward order is A rise, B rise, A fall, B fall
    assign phaseA = ph[0] ^ ph[1];
    assign phaseB = ph[1];
    // gap lets the decoder settle before the next edge
    task automatic step(input logic fwd);
        @(posedge clock);
        ph <= fwd ? ph + 2'h1 : ph - 2'h1;
        repeat (5) @(posedge clock);
    endtask
endmodule

// ---- tb_top.sv ----
// Purpose: self-checking bench for the counter
// Assumes: encoder_model drives the phases
// Notes: one queue holds notes in order of arrival
module tb_top
    import quad_counter_pkg::*;
;
    timeunit 1ns / 1ps;
    logic clock = 1'h0, reset_n = 1'h0, clearCounts = 1'h0, scanStart = 1'h0, d, hit;
    logic [1:0] resolutionSel = 2'h0, pulseIn = 2'h0, ph, v;
    logic [31:0] pos = '0, fw = '0, rv = '0;
    logic cw = 1'h1;
    logic [63:0] expS = '0, pulseSnapshot;
    logic [96:0] lastQ = 97'h1, want, expQ[$];
    wire phaseA, phaseB, snapshotValid;
    quad_result_t quadResult;
    int failures = 0, total_checks = 0, n;
    always #4 clock = ~clock;
    quadrature_pulse_counter u_quadrature_pulse_counter (
        .clock(clock),
        .reset_n(reset_n),
        .phaseA(phaseA),
        .phaseB(phaseB),
        .pulseIn(pulseIn),
        .resolutionSel(resolutionSel),
        .clearCounts(clearCounts),
        .scanStart(scanStart),
        .quadResult(quadResult),
        .pulseSnapshot(pulseSnapshot),
        .snapshotValid(snapshotValid)
    );
    encoder_model u_encoder_model (
        .clock(clock),
        .phaseA(phaseA),
        .phaseB(phaseB)
    );
    task automatic check(input logic [96:0] seen, exp);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // resolution is only loaded with a clear, then moved away
    task automatic clear(input logic [1:0] m);
        @(posedge clock);
        resolutionSel <= m;
        clearCounts <= 1'h1;
        if ({pos, fw, rv, cw} !== 97'h1) expQ.push_back(97'h1);
        {pos, fw, rv, cw} = 97'h1;
        @(posedge clock);
        clearCounts <= 1'h0;
        resolutionSel <= m + 2'h1;
    endtask
    // take the oldest note as each result shows up
    always @(negedge clock) begin
        if (reset_n && quadResult !== lastQ) begin
            // nothing due: the old value is expected, so a stray change fails
            want = expQ.size() > 0 ? expQ.pop_front() : lastQ;
            check(quadResult, want);
            lastQ = quadResult;
        end
        if (snapshotValid === 1'h1) begin
            // a stray snapshot meets a note no 64-bit value can match
            want = expQ.size() > 0 ? expQ.pop_front() : {1'h1, 96'h0};
            check(pulseSnapshot, want);
        end
    end
    // ----
    // main sequence
    // ----
    initial begin
        void'($urandom(70));
        repeat (20) @(posedge clock);
        reset_n <= 1'h1;
        for (int m = 0; m < 4; m++) begin
            clear(m[1:0]);
            repeat (16) begin
                d = 1'($urandom);
                ph = u_encoder_model.ph;
                hit = m % 3 == 0 ? (d ? ph == 2'h0 : ph == 2'h1) : m == 1 ? d ^ ph[0] : 1'h1;
                if (hit) begin
                    {pos, fw, rv, cw} = d ? {pos + 1'h1, fw + 1'h1, rv, 1'h1}
                        : {pos - 1'h1, fw, rv + 1'h1, 1'h0};
                    expQ.push_back({pos, fw, rv, cw});
                end
                u_encoder_model.step(d);
            end
            $display("resolution %0d done", m);
        end
        for (int s = 0; s < 3; s++) begin
            n = $urandom % 40; // short scan, far below a wrap
            repeat (n) begin
                v = 2'($urandom);
                @(posedge clock);
                expS += {31'h0, v[1] & ~pulseIn[1], 31'h0, v[0] & ~pulseIn[0]};
                pulseIn <= v;
                repeat (2) @(posedge clock);
            end
            repeat (4) @(posedge clock);
            pulseIn <= 2'h0;
            repeat (3) @(posedge clock);
            // both rise so that they are counted on the very scan edge
            pulseIn <= 2'h3;
            repeat (2) @(posedge clock);
            scanStart <= 1'h1;
            expQ.push_back(expS);
            // boundary rises open the next interval, none is lost
            expS = 64'h0000000100000001;
            @(posedge clock);
            scanStart <= s == 2; // back-to-back start reads only the boundary rises
            if (s == 2) expQ.push_back(expS);
            @(posedge clock);
            scanStart <= 1'h0;
            $display("scan %0d done", s);
        end
        for (int i = 0; i < 20 && expQ.size() > 0; i++) @(posedge clock);
        if (expQ.size() > 0) failures++;
        final_report();
    end
endmodule
